// *** rtl/iew_addr_write.sv ***
// Functional notes
// - Each access opens with Start then an 8-bit device address byte.
// - Address byte bits 7..4 must hold type code 1010 to match.
// - Small variant: bits 3 and 2 compared with high and low straps.
// - Large variant: only bit 3 compared with the high strap.
// - Small variant: address byte bit 1 is word address bit eight.
// - Large variant: address byte bits 2,1 are word address bits nine,eight.
// - Address byte bit 0 high means read, low means write.
// - Acknowledge a matching address byte, otherwise not-acknowledge.
// - Word address byte follows, giving the low eight address bits.
// - Byte write: ack all bytes; Stop launches the programming cycle.
// - During programming all bus inputs are ignored, no response given.
// - One programming cycle stores one to 16 bytes within one row.
// - Page write: up to fifteen more data bytes, each acknowledged.
// - Page programming starts only at the Stop after the last byte.
// - Each data byte increments only the low four address bits.
// - Low address bits wrap to the first byte of the same page.
// - Bytes go MSB first; ninth clock carries acknowledge.
// - Sample data on SCL rise, change driven data on SCL fall.
// - SDA fall with SCL high is Start, SDA rise is Stop.
`timescale 1ns/10ps
`default_nettype none
module iew_addr_write import iew_pkg::*; #(
  parameter int unsigned ADDR_BITS = ADDR_BITS_4K,
  parameter int unsigned PROG_TIME_NS = PROG_TIME_NS_DEF,
  parameter int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic strapSelectHigh,
  input wire logic strapSelectLow,
  output logic sdaOut,
  output logic sdaOe,
  output logic wrStrobe,
  output logic [BYTE_BITS-1:0] wrData,
  output logic [ADDR_BITS-1:0] wrAddr,
  output logic [ADDR_BITS-1:0] curAddr,
  output logic readReq,
  output logic progStart,
  output logic progBusy
);
  // **********************************************************************
  // Constants and helpers
  // **********************************************************************
  localparam bit WIDE = (ADDR_BITS == ADDR_BITS_8K);
  localparam int unsigned UB = ADDR_BITS - BYTE_BITS;
  localparam int unsigned CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES - 1);

  // Type code and strap comparison of a device address byte
  function automatic logic devMatch(input logic [7:0] b, input logic hi,
                                    input logic lo);
    logic typeOk;
    typeOk = (b[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID);
    devMatch = typeOk && (b[STRAP_HI_BIT] == hi)
               && (WIDE || (b[STRAP_LO_BIT] == lo));
  endfunction

  // **********************************************************************
  // Pin synchronisers
  // **********************************************************************
  logic sclLvl, sclRise, sclFall;
  logic sdaLvl, sdaRise, sdaFall;
  logic strapHi, strapLo;

  iew_pin_sync uSclSync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinIn(sclIn),
    .level(sclLvl),
    .rise(sclRise),
    .fall(sclFall)
  );

  iew_pin_sync uSdaSync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinIn(sdaIn),
    .level(sdaLvl),
    .rise(sdaRise),
    .fall(sdaFall)
  );

  // Straps are static in practice but still arrive from pins
  iew_pin_sync uStrapHiSync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinIn(strapSelectHigh),
    .level(strapHi),
    .rise(),
    .fall()
  );

  iew_pin_sync uStrapLoSync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinIn(strapSelectLow),
    .level(strapLo),
    .rise(),
    .fall()
  );

  // **********************************************************************
  // Bus condition decode
  // **********************************************************************
  iew_state_t stateQ;
  logic [3:0] bitCntQ;
  logic [7:0] shiftQ;
  logic byteDoneQ;
  logic ackPhaseQ;
  logic dataSeenQ;
  logic [CW-1:0] progCntQ;
  logic [ADDR_BITS-1:0] addrQ;
  logic sdaOeQ, sdaOutQ, wrStrobeQ;
  logic [7:0] wrDataQ;
  logic [ADDR_BITS-1:0] wrAddrQ;
  logic readReqQ, progStartQ, progBusyQ;

  logic startDet;
  logic stopDet;
  logic busy;
  logic active;
  logic byteEnd;
  logic ackEnd;
  logic matchNow;
  logic ackNow;
  logic launch;
  logic [1:0] upperSel;

  // SCL must already be high, so a data edge near SCL rise is not taken
  assign startDet = sdaFall && sclLvl && !sclRise;
  assign stopDet = sdaRise && sclLvl && !sclRise;
  assign busy = (stateQ == ST_PROG);
  assign active = (stateQ == ST_DEV) || (stateQ == ST_WORD)
                  || (stateQ == ST_DATA);
  // Bytes are judged on the fall that ends the eighth clock
  assign byteEnd = sclFall && byteDoneQ && !busy;
  assign ackEnd = sclFall && ackPhaseQ && !byteDoneQ && !busy;
  assign matchNow = devMatch(shiftQ, strapHi, strapLo);
  assign ackNow = (stateQ == ST_DEV) ? matchNow :
                  ((stateQ == ST_WORD) || (stateQ == ST_DATA));
  assign launch = stopDet && !busy && (stateQ == ST_DATA)
                  && dataSeenQ;
  assign upperSel = WIDE ? shiftQ[UPPER_HI_BIT:UPPER_LO_BIT]
                         : {1'b0, shiftQ[UPPER_LO_BIT]};

  // **********************************************************************
  // Transaction state
  // **********************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= ST_IDLE;
    end else if (busy) begin
      // Start and Stop are deliberately ignored while programming
      if (progCntQ == '0) begin
        stateQ <= ST_IDLE;
      end
    end else if (startDet) begin
      stateQ <= ST_DEV;
    end else if (stopDet) begin
      stateQ <= launch ? ST_PROG : ST_IDLE;
    end else if (byteEnd) begin
      unique case (stateQ)
        ST_DEV: begin
          if (!matchNow) begin
            stateQ <= ST_IDLE;
          end else if (shiftQ[RW_BIT]) begin
            stateQ <= ST_READ;
          end else begin
            stateQ <= ST_WORD;
          end
        end
        ST_WORD: stateQ <= ST_DATA;
        ST_IDLE, ST_DATA, ST_READ, ST_PROG: stateQ <= stateQ;
      endcase
    end
  end

  // **********************************************************************
  // Bit and byte framing
  // **********************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bitCntQ <= '0;
      shiftQ <= '0;
      byteDoneQ <= 1'b0;
      ackPhaseQ <= 1'b0;
    end else if (startDet || stopDet || busy) begin
      bitCntQ <= '0;
      byteDoneQ <= 1'b0;
      ackPhaseQ <= 1'b0;
    end else if (sclRise && active && !ackPhaseQ && !byteDoneQ) begin
      shiftQ <= {shiftQ[6:0], sdaLvl};
      bitCntQ <= bitCntQ + 4'h1;
      byteDoneQ <= (bitCntQ == LAST_DATA_BIT);
    end else if (byteEnd) begin
      byteDoneQ <= 1'b0;
      ackPhaseQ <= 1'b1;
    end else if (ackEnd) begin
      ackPhaseQ <= 1'b0;
      bitCntQ <= '0;
    end
  end

  // **********************************************************************
  // Acknowledge driver
  // **********************************************************************
  // Driven only from falls, so SDA never moves while SCL is high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sdaOeQ <= 1'b0;
    end else if (startDet || stopDet || busy) begin
      sdaOeQ <= 1'b0;
    end else if (byteEnd) begin
      sdaOeQ <= ackNow;
    end else if (ackEnd) begin
      sdaOeQ <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sdaOutQ <= ACK_LEVEL;
    end else begin
      sdaOutQ <= ACK_LEVEL;
    end
  end

  // **********************************************************************
  // Word address counter and data path
  // **********************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addrQ <= '0;
    end else if (byteEnd) begin
      if ((stateQ == ST_DEV) && matchNow && !shiftQ[RW_BIT]) begin
        addrQ[ADDR_BITS-1:BYTE_BITS] <= upperSel[UB-1:0];
      end else if (stateQ == ST_WORD) begin
        addrQ[BYTE_BITS-1:0] <= shiftQ;
      end else if (stateQ == ST_DATA) begin
        // Row bits held, low nibble wraps inside the page
        addrQ[PAGE_BITS-1:0] <= addrQ[PAGE_BITS-1:0] + PAGE_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrStrobeQ <= 1'b0;
      wrDataQ <= '0;
      wrAddrQ <= '0;
    end else begin
      wrStrobeQ <= byteEnd && (stateQ == ST_DATA);
      if (byteEnd && (stateQ == ST_DATA)) begin
        wrDataQ <= shiftQ;
        wrAddrQ <= addrQ;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataSeenQ <= 1'b0;
    end else if (startDet && !busy) begin
      dataSeenQ <= 1'b0;
    end else if (byteEnd && (stateQ == ST_DATA)) begin
      dataSeenQ <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      readReqQ <= 1'b0;
    end else begin
      readReqQ <= byteEnd && (stateQ == ST_DEV) && matchNow
                  && shiftQ[RW_BIT];
    end
  end

  // **********************************************************************
  // Self-timed programming cycle
  // **********************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      progCntQ <= '0;
      progStartQ <= 1'b0;
      progBusyQ <= 1'b0;
    end else begin
      progStartQ <= launch;
      if (launch) begin
        progCntQ <= PROG_LOAD;
        progBusyQ <= 1'b1;
      end else if (busy) begin
        if (progCntQ == '0) begin
          progBusyQ <= 1'b0;
        end else begin
          progCntQ <= progCntQ - CW'(1);
        end
      end
    end
  end

  assign sdaOut = sdaOutQ;
  assign sdaOe = sdaOeQ;
  assign wrStrobe = wrStrobeQ;
  assign wrData = wrDataQ;
  assign wrAddr = wrAddrQ;
  assign curAddr = addrQ;
  assign readReq = readReqQ;
  assign progStart = progStartQ;
  assign progBusy = progBusyQ;

  // **********************************************************************
  // Assertions
  // **********************************************************************
  a_nack_mismatch: assert property (@(posedge ref_clk) disable iff (!resetn)
    (byteEnd && (stateQ == ST_DEV) && !matchNow) |=> !sdaOeQ)
    else $error("address mismatch was acknowledged");

  a_ack_match: assert property (@(posedge ref_clk) disable iff (!resetn)
    (byteEnd && (stateQ == ST_DEV) && matchNow) |=> sdaOeQ)
    else $error("matching address not acknowledged");

  a_oe_on_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(sdaOeQ) |-> $past(sclFall) && !sclLvl)
    else $error("acknowledge driven outside SCL low");

  a_quiet_prog: assert property (@(posedge ref_clk) disable iff (!resetn)
    busy |=> !sdaOeQ && !wrStrobeQ && !readReqQ)
    else $error("bus answered while programming");

  a_prog_at_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
    progStartQ |-> $past(stopDet) && progBusyQ && busy)
    else $error("programming started without Stop");

  a_row_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrStrobeQ |-> (addrQ[ADDR_BITS-1:PAGE_BITS]
                   == wrAddrQ[ADDR_BITS-1:PAGE_BITS]))
    else $error("page row changed by data byte");

  a_page_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrStrobeQ |-> (addrQ[PAGE_BITS-1:0]
                   == wrAddrQ[PAGE_BITS-1:0] + PAGE_STEP))
    else $error("low address bits did not step by one");

  a_read_dir: assert property (@(posedge ref_clk) disable iff (!resetn)
    readReqQ |-> $past(shiftQ[RW_BIT]) && (stateQ == ST_READ))
    else $error("read selected with direction bit low");

  a_word_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    (byteEnd && (stateQ == ST_WORD)) |=> (stateQ == ST_DATA)
      && (addrQ[BYTE_BITS-1:0] == $past(shiftQ)))
    else $error("word address byte not loaded");

  a_busy_ends: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(progBusyQ) |-> $past(progCntQ) == '0)
    else $error("programming ended before its count");
endmodule
`default_nettype wire

// *** rtl/iew_pkg.sv ***
`default_nettype none
package iew_pkg;
  // Word address widths of the two memory size variants
  localparam int unsigned ADDR_BITS_4K = 9;
  localparam int unsigned ADDR_BITS_8K = 10;

  // Device address byte layout
  localparam logic [3:0] DEV_TYPE_ID = 4'hA;
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned STRAP_HI_BIT = 3;
  localparam int unsigned STRAP_LO_BIT = 2;
  localparam int unsigned UPPER_HI_BIT = 2;
  localparam int unsigned UPPER_LO_BIT = 1;
  localparam int unsigned RW_BIT = 0;

  // Byte framing and page geometry
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam int unsigned PAGE_BITS = 4;
  localparam logic [3:0] PAGE_STEP = 4'h1;

  // Open-drain acknowledge level driven while the enable is high
  localparam logic ACK_LEVEL = 1'b0;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_TIME_NS_DEF = 5000000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_WORD = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_PROG = 6'h20
  } iew_state_t;
endpackage
`default_nettype wire

// *** rtl/iew_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module iew_pin_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Idle bus level is high, so the chain resets high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// *** verification/iew_bus_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Two-wire bus master model
// ****************************************
module iew_bus_master (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sdaOe
);
  // A quarter of the 320 ns link period in 40 ns clocks
  localparam int QTR = 2;

  // Bus idles high; SCL stands still between frames
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end

  task automatic qwait();
    repeat (QTR) @(negedge ref_clk);
  endtask

  // SDA falls while SCL is high; also serves as a repeated start
  task automatic start_cond();
    sdaOe = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sdaOe = 1'b1;
    qwait();
    scl = 1'b0;
    qwait();
  endtask

  // SDA rises while SCL is high
  task automatic stop_cond();
    sdaOe = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sdaOe = 1'b0;
    qwait();
  endtask

  // Data changes only mid-low; ninth clock reads the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaOe = ~b[i];
      qwait();
      scl = 1'b1;
      qwait();
      qwait();
      scl = 1'b0;
      qwait();
    end
    sdaOe = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    qwait();
    ack = (sda === 1'b0);
    scl = 1'b0;
    qwait();
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Bench top: small and large variant on one bus
// ****************************************
module tb_top;
  import iew_pkg::*;
  // Short programming time keeps the run brief
  localparam int unsigned PROGC = 200;
  logic ref_clk, resetn, scl, mOe, sda;
  logic oe4, out4, oe8, out8, wr4, wr8, rd4, rd8, ps4, ps8, busy4, busy8;
  logic [7:0] d4, d8;
  logic [8:0] a4, cur4;
  logic [9:0] a8, cur8;
  int fails = 0, total_checks = 0, cyc = 0, prog4 = 0, prog8 = 0;
  int reads4 = 0, busyRun = 0, busyLen = 0;
  logic [18:0] wq[$];

  // Open-drain wire with pull-up
  assign sda = (mOe | (oe4 & ~out4) | (oe8 & ~out8)) ? 1'b0 : 1'b1;

  // Straps: small part answers to 10 in bits 3:2, large part to 0 in bit 3
  iew_addr_write #(.ADDR_BITS(ADDR_BITS_4K), .PROG_CYCLES(PROGC)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sda),
    .strapSelectHigh(1'b1), .strapSelectLow(1'b0), .sdaOut(out4),
    .sdaOe(oe4), .wrStrobe(wr4), .wrData(d4), .wrAddr(a4), .curAddr(cur4),
    .readReq(rd4), .progStart(ps4), .progBusy(busy4));
  iew_addr_write #(.ADDR_BITS(ADDR_BITS_8K), .PROG_CYCLES(PROGC)) i_dut8 (
    .ref_clk(ref_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sda),
    .strapSelectHigh(1'b0), .strapSelectLow(1'b0), .sdaOut(out8),
    .sdaOe(oe8), .wrStrobe(wr8), .wrData(d8), .wrAddr(a8), .curAddr(cur8),
    .readReq(rd8), .progStart(ps8), .progBusy(busy8));
  iew_bus_master i_master (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sdaOe(mOe));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Monitors and timeout
  // ****************************************
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wr4) wq.push_back({2'b00, a4, d4});
    if (wr8) wq.push_back({1'b1, a8, d8});
    if (ps4) prog4 <= prog4 + 1;
    if (ps8) prog8 <= prog8 + 1;
    if (rd4) reads4 <= reads4 + 1;
    if (busy4) busyRun <= busyRun + 1;
    else if (busyRun != 0) begin
      busyLen <= busyRun;
      busyRun <= 0;
    end
    if (cyc == 20000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    i_master.send_byte(b, a);
    chk(a === exp, $sformatf("acknowledge for byte %2h", b));
  endtask

  // Entry layout: variant flag, ten address bits, data byte
  task automatic expw(input logic [18:0] e);
    logic [18:0] g;
    g = (wq.size() > 0) ? wq.pop_front() : 19'h7FFFF;
    chk(g === e, $sformatf("write strobe %5h, expected %5h", g, e));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (6) @(negedge ref_clk);
    while ((busy4 !== 1'b0 || busy8 !== 1'b0) && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 1000, "programming did not end");
    repeat (4) @(negedge ref_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_byte_write();
    i_master.start_cond();
    xfer(8'hAA, 1'b1);
    xfer(8'h35, 1'b1);
    xfer(8'h5C, 1'b1);
    expw({2'b00, 9'h135, 8'h5C});
    chk(cur4 === 9'h136, "counter after byte write");
    chk(prog4 == 0, "programming before stop");
    i_master.stop_cond();
    repeat (6) @(negedge ref_clk);
    chk(prog4 == 1 && busy4 === 1'b1, "programming not launched");
    // Polling while busy must not be answered
    i_master.start_cond();
    xfer(8'hAA, 1'b0);
    i_master.stop_cond();
    chk(prog4 == 1, "stop taken while busy");
    wait_idle();
    chk(busyLen >= PROGC && busyLen <= PROGC + 1, "busy length");
  endtask

  task automatic t_addr_match();
    for (int i = 0; i < 4; i++) begin
      i_master.start_cond();
      xfer({4'hA, i[1:0], 2'b00}, i != 3);
      i_master.stop_cond();
    end
    i_master.start_cond();
    xfer(8'hB8, 1'b0);
    i_master.stop_cond();
    chk(prog4 == 1 && prog8 == 0, "stop without data programmed");
  endtask

  task automatic t_page_wrap();
    i_master.start_cond();
    xfer(8'hAA, 1'b1);
    xfer(8'h0E, 1'b1);
    xfer(8'h11, 1'b1);
    xfer(8'h22, 1'b1);
    xfer(8'h33, 1'b1);
    expw({2'b00, 9'h10E, 8'h11});
    expw({2'b00, 9'h10F, 8'h22});
    expw({2'b00, 9'h100, 8'h33});
    chk(cur4 === 9'h101, "counter after page wrap");
    chk(prog4 == 1, "page programmed before stop");
    i_master.stop_cond();
    wait_idle();
    chk(prog4 == 2, "page programming missing");
  endtask

  task automatic t_large();
    i_master.start_cond();
    xfer(8'hA6, 1'b1);
    xfer(8'hFF, 1'b1);
    xfer(8'h77, 1'b1);
    xfer(8'h88, 1'b1);
    expw({1'b1, 10'h3FF, 8'h77});
    expw({1'b1, 10'h3F0, 8'h88});
    chk(cur8 === 10'h3F1, "large counter after wrap");
    i_master.stop_cond();
    wait_idle();
    chk(prog8 == 1 && prog4 == 2, "large programming");
  endtask

  task automatic t_read();
    i_master.start_cond();
    xfer(8'hA9, 1'b1);
    i_master.stop_cond();
    repeat (6) @(negedge ref_clk);
    chk(reads4 == 1 && prog4 == 2, "read request");
    chk(wq.size() == 0 && cur4 === 9'h101, "read changed state");
  endtask

  initial begin
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_byte_write();
    t_addr_match();
    t_page_wrap();
    t_large();
    t_read();
    wrap_up();
  end
endmodule
`default_nettype wire
